//--- core/jrt_consts.svh
// Purpose: constants of the transport and latency block
// Assumes: included by bare name
// Notes: mode keys are {M-1,L-1,S-1,F-1}, one nibble each
`ifndef JRT_CONSTS_SVH
`define JRT_CONSTS_SVH
`define JRT_ADDR_LAT0 12'h302
`define JRT_ADDR_LAT1 12'h303
`define JRT_ADDR_MFD_A 12'h304
`define JRT_ADDR_MFD_B 12'h305
`define JRT_ADDR_VAR_A 12'h306
`define JRT_ADDR_VAR_B 12'h307
`define JRT_REG_RST 8'h00
`define JRT_VAR_MAX 8'h0a
`define JRT_K_LONG_M1 5'h1f
`define JRT_K_SHORT_M1 5'h0f
`define JRT_RES_M1 5'h0f
`define JRT_SUBCLASS_MAX 3'h1
`define JRT_DUAL_M_M1_MAX 8'h01
`define JRT_MODE0_KEY 16'h3700
`define JRT_MODE1_KEY 16'h3711
`define JRT_MODE2_KEY 16'h3301
`define JRT_MODE3_KEY 16'h3103
`define JRT_MODE4_KEY 16'h1300
`define JRT_MODE5_KEY 16'h1311
`define JRT_MODE6_KEY 16'h1101
`define JRT_MODE7_KEY 16'h1003
`define JRT_MODE9_KEY 16'h0100
`define JRT_MODE10_KEY 16'h0001
`endif

//--- core/jrt_pkg.sv
// Purpose: types of the transport and latency block
// Assumes: nothing
// Notes: state of each module is one packed struct
package jrt_pkg;
  typedef enum logic [3:0] {
    JRT_IDLE = 4'b0001,
    JRT_WAIT = 4'b0010,
    JRT_COUNT = 4'b0100,
    JRT_RUN = 4'b1000
  } jrt_rel_type;

  typedef struct packed {
    logic [7:0] mfd_a;
    logic [7:0] mfd_b;
    logic [7:0] var_a;
    logic [7:0] var_b;
    logic [7:0] rdata;
    jrt_rel_type rel;
    logic [3:0] rel_cnt;
    logic err_lmfs;
    logic err_k;
    logic err_dly;
    logic [255:0] smp;
    logic vld;
    logic [2:0] spc;
  } jrt_top_type;

  typedef struct packed {
    logic [5:0] cnt;
    logic [7:0] lat;
    logic armed;
  } jrt_lat_type;
endpackage

//--- core/jrt_latency.sv
// Purpose: per-link latency counter and one-shot capture
// Assumes: inputs synchronous to clk_in, period_in at least 1
// Notes: count wraps each multiframe; software unwraps
`timescale 1ns/100ps
`include "jrt_consts.svh"
module jrt_latency (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic lmfc_in,
  input wire logic ilas_end_in,
  input wire logic relink_in,
  input wire logic [5:0] period_in,
  output logic [7:0] latency_out
);
  jrt_pkg::jrt_lat_type q_q;
  jrt_pkg::jrt_lat_type d_d;
  logic [5:0] now_w;

  // the multiframe edge itself reads as zero
  assign now_w = lmfc_in ? 6'h00 : q_q.cnt;

  always_comb begin
    d_d = q_q;
    if (now_w + 6'h01 >= period_in) begin
      d_d.cnt = 6'h00;
    end else begin
      d_d.cnt = now_w + 6'h01;
    end
    if (relink_in) begin
      d_d.armed = 1'b1;
    end else if (ilas_end_in && q_q.armed) begin
      d_d.lat = {2'b00, now_w};
      d_d.armed = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      q_q <= '{cnt: 6'h00, lat: `JRT_REG_RST, armed: 1'b1};
    end else begin
      q_q <= d_d;
    end
  end

  assign latency_out = q_q.lat;

  a_capture_value: assert property (@(posedge clk_in) disable iff (reset_in)
    ilas_end_in && q_q.armed && !relink_in |=> latency_out == {2'b00, $past(now_w)})
    else $error("latency not captured at ilas end");

  a_count_wraps: assert property (@(posedge clk_in) disable iff (reset_in)
    q_q.cnt < period_in || $changed(period_in))
    else $error("latency count beyond multiframe");

  a_hold_stable: assert property (@(posedge clk_in) disable iff (reset_in)
    !q_q.armed && !relink_in |=> $stable(latency_out) [*1] ##0 !q_q.armed || $past(relink_in))
    else $error("captured latency changed without relink");
endmodule

//--- core/jrt_transport.sv
// Purpose: receive transport deframer with link latency readback
// Assumes: clk_in is the core clock, one per four octets per lane
// Notes: config and status are plain pins; delay regs sit on reg port
// Notes on behaviour
// - latency readback per link at two addresses
// - latency counts modulo one multiframe, wraps
// - deframe lane octets into converter samples
// - octets per frame only 1, 2, 4
// - K is 32 for F=1, else 16/32
// - lane count limits single and dual link
// - converter count limits single and dual link
// - samples per converter per frame 1 or 2
// - control words and bits must be zero
// - high density set exactly when F is 1
// - resolution and bits per sample both 16
// - only the ten listed single link modes
// - dual link allows modes 4 to 10
// - frame clock is 4/F times core clock
// - frames per core clock equals 4/F
// - release delay zero to ten core clocks
// - separate flags for mode, K, delay errors
`timescale 1ns/100ps
`include "jrt_consts.svh"
module jrt_transport (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic dual_link_in,
  input wire logic [4:0] l_m1_in,
  input wire logic [7:0] f_m1_in,
  input wire logic [4:0] k_m1_in,
  input wire logic [7:0] m_m1_in,
  input wire logic [4:0] n_m1_in,
  input wire logic [4:0] np_m1_in,
  input wire logic [4:0] s_m1_in,
  input wire logic hd_in,
  input wire logic [4:0] cf_in,
  input wire logic [1:0] cs_in,
  input wire logic [2:0] subclass_in,
  input wire logic [1:0] lmfc_in,
  input wire logic [1:0] ilas_end_in,
  input wire logic [1:0] relink_in,
  input wire logic [1:0] frame_valid_in,
  input wire logic [255:0] lane_data_in,
  output logic [255:0] samples_out,
  output logic sample_valid_out,
  output logic [2:0] samples_per_conv_out,
  output logic [7:0] link0_mf_delay_out,
  output logic [7:0] link1_mf_delay_out,
  output logic err_lmfs_out,
  output logic err_k_out,
  output logic err_delay_out
);
  jrt_pkg::jrt_top_type q_q;
  jrt_pkg::jrt_top_type d_d;
  logic [7:0] lat0_w;
  logic [7:0] lat1_w;
  logic [1:0] fsh_w;
  logic [5:0] period_w;
  logic [5:0] k_w;
  logic mode_ok_w;

  function automatic logic mode_ok(input logic [7:0] m1, input logic [4:0] l1,
                                   input logic [4:0] s1, input logic [7:0] f1,
                                   input logic dual);
    logic [15:0] key;
    logic hit;
    key = {m1[3:0], l1[3:0], s1[3:0], f1[3:0]};
    case (key)
      `JRT_MODE0_KEY, `JRT_MODE1_KEY, `JRT_MODE2_KEY, `JRT_MODE3_KEY,
      `JRT_MODE4_KEY, `JRT_MODE5_KEY, `JRT_MODE6_KEY, `JRT_MODE7_KEY,
      `JRT_MODE9_KEY, `JRT_MODE10_KEY: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    // upper bits must be clear or the nibble key aliases
    if (m1[7:4] != 4'h0 || l1[4] || s1[4] || f1[7:4] != 4'h0) begin
      hit = 1'b0;
    end
    if (dual && m1 > `JRT_DUAL_M_M1_MAX) begin
      hit = 1'b0;
    end
    return hit;
  endfunction

  function automatic logic [7:0] get_octet(input logic [255:0] d,
                                           input int lane, input int pos);
    logic [7:0] r;
    r = 8'h00;
    // first octet in time sits in the top byte of each lane word
    if (lane >= 0 && lane < 8 && pos >= 0 && pos < 4) begin
      r = d[lane*32 + (3-pos)*8 +: 8];
    end
    return r;
  endfunction

  // log2 of F; frames per core clock is 4 >> fsh
  assign fsh_w = (f_m1_in == 8'h00) ? 2'd0 :
                 (f_m1_in == 8'h01) ? 2'd1 : 2'd2;
  assign k_w = {1'b0, k_m1_in} + 6'h01;
  // core clocks per multiframe is K / (4/F)
  assign period_w = ((k_w >> (2'd2 - fsh_w)) == 6'h00) ? 6'h01 :
                    (k_w >> (2'd2 - fsh_w));

  assign mode_ok_w = mode_ok(m_m1_in, l_m1_in, s_m1_in, f_m1_in, dual_link_in)
    && (hd_in == (f_m1_in == 8'h00))
    && n_m1_in == `JRT_RES_M1 && np_m1_in == `JRT_RES_M1
    && cf_in == 5'h00 && cs_in == 2'h0;

  always_comb begin
    int fv;
    int sv;
    int mv;
    int j;
    int n;
    int gc;
    logic [7:0] hi;
    logic [7:0] lo;
    logic [7:0] var_lim;
    fv = 1 << fsh_w;
    sv = s_m1_in[0] ? 2 : 1;
    mv = int'(m_m1_in[2:0]) + 1;
    j = 0;
    n = 0;
    gc = 0;
    hi = 8'h00;
    lo = 8'h00;
    var_lim = (q_q.var_a > `JRT_VAR_MAX) ? `JRT_VAR_MAX : q_q.var_a;
    d_d = q_q;

    if (reg_wr_in) begin
      case (reg_addr_in)
        `JRT_ADDR_MFD_A: d_d.mfd_a = reg_wdata_in;
        `JRT_ADDR_MFD_B: d_d.mfd_b = reg_wdata_in;
        `JRT_ADDR_VAR_A: d_d.var_a = reg_wdata_in;
        `JRT_ADDR_VAR_B: d_d.var_b = reg_wdata_in;
        default: d_d.mfd_a = q_q.mfd_a;
      endcase
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        `JRT_ADDR_LAT0: d_d.rdata = lat0_w;
        `JRT_ADDR_LAT1: d_d.rdata = lat1_w;
        `JRT_ADDR_MFD_A: d_d.rdata = q_q.mfd_a;
        `JRT_ADDR_MFD_B: d_d.rdata = q_q.mfd_b;
        `JRT_ADDR_VAR_A: d_d.rdata = q_q.var_a;
        `JRT_ADDR_VAR_B: d_d.rdata = q_q.var_b;
        default: d_d.rdata = 8'h00;
      endcase
    end

    d_d.err_lmfs = !mode_ok_w;
    d_d.err_k = !(k_m1_in == `JRT_K_LONG_M1 ||
                 (k_m1_in == `JRT_K_SHORT_M1 && f_m1_in != 8'h00));
    // delay is in frame clocks so it must stay below K
    d_d.err_dly = q_q.mfd_a > {3'h0, k_m1_in} || q_q.mfd_b > {3'h0, k_m1_in}
      || q_q.var_a > `JRT_VAR_MAX || q_q.var_b > `JRT_VAR_MAX
      || subclass_in > `JRT_SUBCLASS_MAX;

    // release gate: a common start for both links, counted from link 0
    case (q_q.rel)
      jrt_pkg::JRT_IDLE: begin
        if (ilas_end_in[0]) begin
          d_d.rel = jrt_pkg::JRT_WAIT;
        end
      end
      jrt_pkg::JRT_WAIT: begin
        if (lmfc_in[0]) begin
          d_d.rel_cnt = var_lim[3:0];
          d_d.rel = (var_lim == 8'h00) ? jrt_pkg::JRT_RUN
                                       : jrt_pkg::JRT_COUNT;
        end
      end
      jrt_pkg::JRT_COUNT: begin
        d_d.rel_cnt = q_q.rel_cnt - 4'h1;
        if (q_q.rel_cnt <= 4'h1) begin
          d_d.rel = jrt_pkg::JRT_RUN;
        end
      end
      jrt_pkg::JRT_RUN: d_d.rel = jrt_pkg::JRT_RUN;
      default: d_d.rel = jrt_pkg::JRT_IDLE;
    endcase
    if (relink_in[0]) begin
      d_d.rel = jrt_pkg::JRT_IDLE;
    end

    // deframe: frame octet j lives on lane j/F at octet j%F of its frame
    d_d.smp = '0;
    for (int k = 0; k < 2; k++) begin
      for (int c = 0; c < 4; c++) begin
        for (int f = 0; f < 4; f++) begin
          for (int s = 0; s < 2; s++) begin
            n = f*sv + s;
            if (mode_ok_w && (k == 0 || dual_link_in) && c < mv && s < sv
                && f < (4 >> fsh_w) && n < 4) begin
              j = 2*(c*sv + s);
              gc = dual_link_in ? k*2 + c : c;
              hi = get_octet(lane_data_in, (j >> fsh_w) + k*4,
                             f*fv + (j % fv));
              lo = get_octet(lane_data_in, ((j+1) >> fsh_w) + k*4,
                             f*fv + ((j+1) % fv));
              d_d.smp[(gc*4 + n)*16 +: 16] = {hi, lo};
            end
          end
        end
      end
    end
    d_d.spc = mode_ok_w ? 3'((4 >> fsh_w) * sv) : 3'h0;
    d_d.vld = mode_ok_w && q_q.rel == jrt_pkg::JRT_RUN && frame_valid_in[0]
      && (!dual_link_in || frame_valid_in[1]);
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      q_q <= '{mfd_a: `JRT_REG_RST, mfd_b: `JRT_REG_RST,
               var_a: `JRT_REG_RST, var_b: `JRT_REG_RST,
               rdata: 8'h00, rel: jrt_pkg::JRT_IDLE, rel_cnt: 4'h0,
               err_lmfs: 1'b0, err_k: 1'b0, err_dly: 1'b0,
               smp: 256'h0, vld: 1'b0, spc: 3'h0};
    end else begin
      q_q <= d_d;
    end
  end

  jrt_latency u_lat0 (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .lmfc_in(lmfc_in[0]),
    .ilas_end_in(ilas_end_in[0]),
    .relink_in(relink_in[0]),
    .period_in(period_w),
    .latency_out(lat0_w)
  );

  jrt_latency u_lat1 (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .lmfc_in(lmfc_in[1]),
    .ilas_end_in(ilas_end_in[1]),
    .relink_in(relink_in[1]),
    .period_in(period_w),
    .latency_out(lat1_w)
  );

  assign reg_rdata_out = q_q.rdata;
  assign samples_out = q_q.smp;
  assign sample_valid_out = q_q.vld;
  assign samples_per_conv_out = q_q.spc;
  assign link0_mf_delay_out = q_q.mfd_a;
  assign link1_mf_delay_out = q_q.mfd_b;
  assign err_lmfs_out = q_q.err_lmfs;
  assign err_k_out = q_q.err_k;
  assign err_delay_out = q_q.err_dly;

  sequence s_release_armed;
    q_q.rel == jrt_pkg::JRT_WAIT && lmfc_in[0] && !relink_in[0];
  endsequence

  sequence s_released;
    q_q.rel == jrt_pkg::JRT_RUN || relink_in[0];
  endsequence

  a_release_bound: assert property (@(posedge clk_in) disable iff (reset_in)
    s_release_armed |=> ##[0:10] s_released)
    else $error("release not reached within ten core clocks");

  a_latency_read: assert property (@(posedge clk_in) disable iff (reset_in)
    reg_rd_in && reg_addr_in == `JRT_ADDR_LAT1 |=> reg_rdata_out == $past(lat1_w))
    else $error("link 1 latency readback wrong");

  a_valid_gated: assert property (@(posedge clk_in) disable iff (reset_in)
    sample_valid_out |-> $past(q_q.rel) == jrt_pkg::JRT_RUN && $past(mode_ok_w))
    else $error("samples valid before release");

  a_k_single_octet: assert property (@(posedge clk_in) disable iff (reset_in)
    f_m1_in == 8'h00 && k_m1_in != `JRT_K_LONG_M1 |=> err_k_out)
    else $error("short multiframe with F of one not flagged");

  a_dual_converters: assert property (@(posedge clk_in) disable iff (reset_in)
    dual_link_in && m_m1_in > `JRT_DUAL_M_M1_MAX |=> err_lmfs_out)
    else $error("four converters per link in dual mode not flagged");

  a_high_density: assert property (@(posedge clk_in) disable iff (reset_in)
    hd_in != (f_m1_in == 8'h00) |=> err_lmfs_out && !sample_valid_out)
    else $error("high density mismatch not flagged");

  a_var_range: assert property (@(posedge clk_in) disable iff (reset_in)
    q_q.var_b > `JRT_VAR_MAX |=> err_delay_out)
    else $error("variation above ten not flagged");

  a_rate_ratio: assert property (@(posedge clk_in) disable iff (reset_in)
    sample_valid_out |-> samples_per_conv_out ==
      3'((4 >> $past(fsh_w)) * ($past(s_m1_in[0]) ? 2 : 1)))
    else $error("samples per core clock not 4/F times S");

  a_control_zero: assert property (@(posedge clk_in) disable iff (reset_in)
    cf_in != 5'h00 || cs_in != 2'h0 |=> err_lmfs_out)
    else $error("control words accepted");
endmodule

//--- verif/jrt_tx_model.sv
// Purpose: transmitter side model: link events and lane data
// Assumes: one shared core clock, both links start together
// Notes: lane n word is {c, ~c}, c = count ^ n<<12, so lanes differ
`timescale 1ns/100ps
module jrt_tx_model (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [5:0] period_in,
  input wire logic [5:0] offset_in,
  input wire logic go_in,
  input wire logic rearm_in,
  output logic [1:0] lmfc_out,
  output logic [1:0] ilas_end_out,
  output logic [1:0] relink_out,
  output logic [1:0] frame_valid_out,
  output logic [255:0] lane_data_out
);
  logic [5:0] mf_q = 6'h00;
  logic [5:0] wt_q = 6'h00;
  logic [15:0] cnt_q = 16'h0000;
  logic [1:0] st_q = 2'h0;
  logic [1:0] rl_q = 2'h0;
  logic in_ilas;
  assign in_ilas = st_q == 2'h2;
  assign lmfc_out = {2{mf_q == 6'h00}};
  // link 1 ends ilas one cycle after link 0
  assign ilas_end_out[0] = in_ilas && wt_q == offset_in;
  assign ilas_end_out[1] = in_ilas && wt_q == offset_in + 6'h01;
  assign relink_out = rl_q;
  assign frame_valid_out = {2{st_q == 2'h3}};
  // no control words or bits, 16-bit samples only
  // lane number in the top nibble catches a wrong lane or link offset
  for (genvar n = 0; n < 8; n++) begin : g_lane
    assign lane_data_out[n*32 +: 32] = {cnt_q ^ 16'(n << 12),
      ~(cnt_q ^ 16'(n << 12))};
  end
  always @(posedge clk_in) begin
    cnt_q <= reset_in ? 16'h0000 : cnt_q + 16'h0001;
    mf_q <= (reset_in || mf_q + 6'h01 >= period_in) ? 6'h00 : mf_q + 6'h01;
    wt_q <= wt_q + 6'h01;
    rl_q <= 2'h0;
    if (reset_in) begin
      st_q <= 2'h0;
    end else if (st_q == 2'h0 && go_in) begin
      st_q <= 2'h1;
      rl_q <= {2{rearm_in}};
    end else if (st_q == 2'h1 && mf_q == 6'h00) begin
      st_q <= 2'h2;
      wt_q <= 6'h01;
    end else if (in_ilas && wt_q > offset_in) begin
      st_q <= 2'h3;
    end else if (st_q == 2'h3 && !go_in) begin
      st_q <= 2'h0;
    end
  end
endmodule

//--- verif/jrt_transport_bench.sv
// Purpose: register, config check and latency tests of the transport
// Assumes: inputs change 1 ns after the rising edge
// Notes: sample checks rely on the model's count pattern only
`timescale 1ns/100ps
`include "jrt_consts.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module jrt_transport_bench;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [11:0] addr = 12'h000;
  logic wr = 1'b0, rd = 1'b0, dual = 1'b0, hd = 1'b0;
  logic go = 1'b0, rearm = 1'b0;
  logic [7:0] wdata = 8'h00, f_m1 = 8'h00, m_m1 = 8'h00;
  logic [7:0] rdata, d0, d1;
  logic [4:0] l_m1 = 5'h00, k_m1 = 5'h1f, n_m1 = 5'h0f, np_m1 = 5'h0f;
  logic [4:0] s_m1 = 5'h00, cf = 5'h00;
  logic [1:0] cs = 2'h0;
  logic [2:0] subclass = 3'h1;
  logic [5:0] offset = 6'h03;
  logic [1:0] lmfc, ilas, relink, fv;
  logic [255:0] lanes, smp;
  logic svld, e_l, e_k, e_d;
  logic [2:0] spc;
  logic [15:0] s0, prev;
  int error_cnt = 0, n_tests = 0, i, j;
  logic [15:0] keys [10] = '{`JRT_MODE0_KEY, `JRT_MODE1_KEY, `JRT_MODE2_KEY,
    `JRT_MODE3_KEY, `JRT_MODE4_KEY, `JRT_MODE5_KEY, `JRT_MODE6_KEY,
    `JRT_MODE7_KEY, `JRT_MODE9_KEY, `JRT_MODE10_KEY};
  jrt_transport dut (.clk_in(clk_in), .reset_in(reset_in),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .dual_link_in(dual),
    .l_m1_in(l_m1), .f_m1_in(f_m1), .k_m1_in(k_m1), .m_m1_in(m_m1),
    .n_m1_in(n_m1), .np_m1_in(np_m1), .s_m1_in(s_m1), .hd_in(hd),
    .cf_in(cf), .cs_in(cs), .subclass_in(subclass), .lmfc_in(lmfc),
    .ilas_end_in(ilas), .relink_in(relink), .frame_valid_in(fv),
    .lane_data_in(lanes), .samples_out(smp), .sample_valid_out(svld),
    .samples_per_conv_out(spc), .link0_mf_delay_out(d0),
    .link1_mf_delay_out(d1), .err_lmfs_out(e_l), .err_k_out(e_k),
    .err_delay_out(e_d));
  // period 8 matches K=16, F=2 used in the latency runs
  jrt_tx_model far (.clk_in(clk_in), .reset_in(reset_in),
    .period_in(6'h08), .offset_in(offset), .go_in(go), .rearm_in(rearm),
    .lmfc_out(lmfc), .ilas_end_out(ilas), .relink_out(relink),
    .frame_valid_out(fv), .lane_data_out(lanes));
  always #4 clk_in = ~clk_in;
  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    tick();
    wr = 1'b0;
    tick();
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] x);
    addr = a;
    rd = 1'b1;
    tick();
    rd = 1'b0;
    tick();
    `CHK(rdata, x)
  endtask
  task automatic cfg(input logic [15:0] key, input logic dl);
    m_m1 = {4'h0, key[15:12]};
    l_m1 = {1'b0, key[11:8]};
    s_m1 = {1'b0, key[7:4]};
    f_m1 = {4'h0, key[3:0]};
    hd = key[3:0] == 4'h0;
    dual = dl;
    k_m1 = `JRT_K_LONG_M1;
    {n_m1, np_m1, cf, cs, subclass} = {5'h0f, 5'h0f, 5'h00, 2'h0, 3'h1};
  endtask
  // flags are recomputed from config one cycle later, so allow two
  task automatic flags(input logic [2:0] x);
    tick();
    tick();
    `CHK({e_l, e_k, e_d}, x)
  endtask
  task automatic fault(input int t, input logic [2:0] x);
    cfg(keys[2], 1'b0);
    case (t)
      0: f_m1 = 8'h02;
      1: s_m1 = 5'h02;
      2: cf = 5'h01;
      3: cs = 2'h1;
      4: hd = 1'b1;
      5: n_m1 = 5'h0e;
      6: np_m1 = 5'h0e;
      7: subclass = 3'h2;
      default: k_m1 = `JRT_K_SHORT_M1;
    endcase
    flags(x);
  endtask
  task automatic wait_for(input int w);
    for (i = 0; i < 100; i++) begin
      if ((w == 0 ? fv[0] : svld) === 1'b1) break;
      tick();
    end
    if (i == 100) begin
      error_cnt++;
      $display("[ERR] %0t wait ran out", $time);
      end_sim();
    end
  endtask
  task automatic lat(input logic [5:0] off, input logic re,
                     input logic [7:0] x0, input logic [7:0] x1);
    int k;
    offset = off;
    rearm = re;
    go = 1'b1;
    wait_for(0);
    wait_for(1);
    `CHK(spc, 3'h2)
    for (k = 0; k < 4; k++) begin
      s0 = smp[15:0];
      `CHK(svld, 1'b1)
      `CHK(smp[31:16], ~s0)
      if (k > 0) `CHK(s0, prev + 16'h0001)
      `CHK(smp[143:128], dual ? s0 ^ 16'h4000 : 16'h0000)
      prev = s0;
      tick();
    end
    go = 1'b0;
    repeat (3) tick();
    `CHK(svld, 1'b0)
    rd_chk(12'h302, x0);
    rd_chk(12'h303, x1);
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    #1;
    reset_in = 1'b0;
    for (j = 0; j < 6; j++) begin
      rd_chk(12'h302 + 12'(j), `JRT_REG_RST);
    end
    for (j = 0; j < 10; j++) begin
      cfg(keys[j], 1'b0);
      flags(3'b000);
      cfg(keys[j], 1'b1);
      flags({j < 4, 2'b00});
    end
    for (j = 0; j < 7; j++) begin
      fault(j, 3'b100);
    end
    fault(7, 3'b001);
    fault(8, 3'b000);
    cfg(keys[0], 1'b0);
    k_m1 = `JRT_K_SHORT_M1;
    flags(3'b010);
    // delay held at zero while latency is characterised
    cfg(keys[9], 1'b0);
    k_m1 = `JRT_K_SHORT_M1;
    lat(6'h03, 1'b1, 8'h03, 8'h04);
    lat(6'h05, 1'b0, 8'h03, 8'h04);
    lat(6'h07, 1'b1, 8'h07, 8'h00);
    cfg(keys[9], 1'b1);
    k_m1 = `JRT_K_SHORT_M1;
    lat(6'h02, 1'b1, 8'h02, 8'h03);
    wr_reg(12'h306, 8'h0b);
    flags(3'b001);
    wr_reg(12'h306, `JRT_VAR_MAX);
    flags(3'b000);
    wr_reg(12'h304, 8'h10);
    flags(3'b001);
    // host math on extremes 4 and 9: var 7, delay 6 frame clocks
    for (j = 0; j < 4; j++) begin
      wr_reg(12'h304 + 12'(j), j < 2 ? 8'(((4 - 1) * 2) % 16) :
             8'((9 + 1) - (4 - 1)));
    end
    for (j = 0; j < 4; j++) begin
      rd_chk(12'h304 + 12'(j), j < 2 ? 8'h06 : 8'h07);
    end
    `CHK({d0, d1}, 16'h0606)
    flags(3'b000);
    wr_reg(12'h302, 8'h55);
    rd_chk(12'h302, 8'h02);
    rd_chk(12'h308, 8'h00);
    end_sim();
  end
endmodule
